// ### inc/dds_pkg.sv
/*
 * Constants for the device diagnostics supervisor: timing counts, status bit positions.
 * Assumes a single 25 MHz system clock.
 */
package dds_pkg;

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    localparam int unsigned CLK_HZ          = 25000000;

    // ----------------------------------------
    // Monitor deglitch
    // ----------------------------------------
    localparam int unsigned OV_DEGLITCH_US  = 20;
    localparam int unsigned OV_DEGLITCH_CYC = OV_DEGLITCH_US * (CLK_HZ / 1000000);
    localparam int unsigned SLOW_DEGLITCH_MS  = 2;
    localparam int unsigned SLOW_DEGLITCH_CYC = SLOW_DEGLITCH_MS * (CLK_HZ / 1000);
    localparam int unsigned DEGLITCH_W      = 16;

    // ----------------------------------------
    // Low-side fault timer
    // ----------------------------------------
    localparam int unsigned LS_SHORT_US     = 1;
    localparam int unsigned LS_LONG_US      = 2;
    localparam int unsigned LS_SHORT_CYC    = LS_SHORT_US * (CLK_HZ / 1000000);
    localparam int unsigned LS_LONG_CYC     = LS_LONG_US * (CLK_HZ / 1000000);
    localparam int unsigned LS_W            = 8;

    // ----------------------------------------
    // Software watchdog
    // ----------------------------------------
    localparam int unsigned SW_WD_MS        = 250;
    localparam int unsigned SW_WD_CYC       = SW_WD_MS * (CLK_HZ / 1000);
    localparam int unsigned SW_WD_W         = 23;

    // ----------------------------------------
    // RAM self test
    // ----------------------------------------
    localparam int unsigned BIST_MS         = 5;
    localparam int unsigned BIST_CYC        = BIST_MS * (CLK_HZ / 1000);
    localparam int unsigned BIST_W          = 18;

    // ----------------------------------------
    // Oscillator watchdog: window of ref ticks, main clock edges counted
    // ----------------------------------------
    localparam int unsigned OSC_REF_HZ      = 500000;
    localparam int unsigned OSC_WIN_TICKS   = 16;
    localparam int unsigned OSC_LOW_MHZ10   = 100;
    localparam int unsigned OSC_HIGH_MHZ10  = 300;
    localparam int unsigned OSC_MIN_CNT     = OSC_LOW_MHZ10 * 100000 * OSC_WIN_TICKS / OSC_REF_HZ;
    localparam int unsigned OSC_MAX_CNT     = OSC_HIGH_MHZ10 * 100000 * OSC_WIN_TICKS / OSC_REF_HZ;
    localparam int unsigned OSC_W           = 12;
    localparam int unsigned SAMPLE_W        = 4;

    // ----------------------------------------
    // Status bit positions
    // ----------------------------------------
    localparam int unsigned ST1_SUPPLY_OV   = 0;
    localparam int unsigned ST1_REG_UV      = 1;
    localparam int unsigned ST1_REG_OC      = 2;
    localparam int unsigned ST1_BIAS_OC     = 3;
    localparam int unsigned ST1_TRIM_FAIL   = 4;
    localparam int unsigned ST1_BIST_DONE   = 5;
    localparam int unsigned ST1_BIST_FAIL   = 6;
    localparam int unsigned ST2_LS_FAULT    = 0;
    localparam int unsigned MON_COUNT       = 4;

    typedef enum logic [1:0] {
        DDS_BIST_IDLE,
        DDS_BIST_RUN,
        DDS_BIST_END
    } dds_bist_type;

endpackage

// ### verilog/dds_supervisor.sv
/*
 * Device diagnostics supervisor: monitor deglitch, low-side FET guard, oscillator
 * watchdog, software watchdog, trim check and RAM self-test sequencing.
 * Assumes monitor pins, service pin and reference clock are asynchronous to clk_sys,
 * and that RAM test pass/fail and trim validity come from logic on clk_sys.
 */
module dds_supervisor
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic                           osc_ref_clk,
    input  wire logic [dds_pkg::MON_COUNT-1:0]  monitor_raw,
    input  wire logic                           gate_cmd,
    input  wire logic                           gate_monitor,
    input  wire logic                           drain_monitor,
    input  wire logic                           low_side_fault_enable,
    input  wire logic                           low_side_fault_time_select,
    input  wire logic                           oscillator_watchdog_enable,
    input  wire logic                           software_watchdog_enable_set,
    input  wire logic                           software_watchdog_enable_clr,
    input  wire logic                           serial_core_reset,
    input  wire logic                           service_pin,
    input  wire logic                           trim_valid,
    input  wire logic                           bist_pass,
    output logic                                gate_drive,
    output logic                                drive_off,
    output logic                                core_reset,
    output logic                                digital_reset,
    output logic                                software_watchdog_enable,
    output logic [7:0]                          first_status_register,
    output logic [7:0]                          second_status_register,
    output logic                                ram_self_test_done,
    output logic                                bist_run
);
    import dds_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [MON_COUNT-1:0] mon_s1;
    logic [MON_COUNT-1:0] mon_s2;
    logic                 gm_s1;
    logic                 gm_s2;
    logic                 dm_s1;
    logic                 dm_s2;
    logic                 svc_s1;
    logic                 svc_s2;
    logic                 svc_d;
    logic                 ref_s1;
    logic                 ref_s2;
    logic                 ref_d;
    logic                 por_n;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mon_s1 <= '0;
            mon_s2 <= '0;
            gm_s1  <= 1'b0;
            gm_s2  <= 1'b0;
            dm_s1  <= 1'b0;
            dm_s2  <= 1'b0;
            svc_s1 <= 1'b0;
            svc_s2 <= 1'b0;
            svc_d  <= 1'b0;
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_d  <= 1'b0;
        end
        else
        begin
            mon_s1 <= monitor_raw;
            mon_s2 <= mon_s1;
            gm_s1  <= gate_monitor;
            gm_s2  <= gm_s1;
            dm_s1  <= drain_monitor;
            dm_s2  <= dm_s1;
            svc_s1 <= service_pin;
            svc_s2 <= svc_s1;
            svc_d  <= svc_s2;
            ref_s1 <= osc_ref_clk;
            ref_s2 <= ref_s1;
            ref_d  <= ref_s2;
        end
    end

    // ----------------------------------------
    // Power-block monitor deglitch
    // ----------------------------------------
    logic [MON_COUNT-1:0] mon_fault;
    logic                 osc_fail;

    // Internal core reset: external reset or oscillator failure
    // core-wide reset
    assign por_n = rst_n && !osc_fail;

    genvar gi;
    generate
        for (gi = 0; gi < MON_COUNT; gi++)
        begin : g_mon
            localparam logic [DEGLITCH_W-1:0] LIMIT = (gi == ST1_SUPPLY_OV)
                ? DEGLITCH_W'(OV_DEGLITCH_CYC) : DEGLITCH_W'(SLOW_DEGLITCH_CYC);
            logic [DEGLITCH_W-1:0] cnt;
            always_ff @(posedge clk_sys)
            begin
                if (!por_n || !mon_s2[gi])
                    cnt <= '0;
                else if (cnt != LIMIT)
                    cnt <= cnt + 1'b1;
            end
            always_ff @(posedge clk_sys)
            begin
                if (!por_n || !mon_s2[gi])
                    mon_fault[gi] <= 1'b0;
                else if (cnt == LIMIT)
                    mon_fault[gi] <= 1'b1;
            end
        end
    endgenerate

    // ----------------------------------------
    // Low-side FET guard
    // ----------------------------------------
    logic            gate_cmd_d;
    logic            ls_armed;
    logic            ls_fault;
    logic [LS_W-1:0] ls_cnt;
    logic [LS_W-1:0] ls_limit;
    logic            sw_timeout;

    assign ls_limit = low_side_fault_time_select ? LS_W'(LS_LONG_CYC) : LS_W'(LS_SHORT_CYC);

    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            gate_cmd_d <= 1'b0;
        else
            gate_cmd_d <= gate_cmd;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            ls_armed <= 1'b0;
        else if (!gate_cmd || ls_fault)
            ls_armed <= 1'b0;
        else if (gate_cmd && !gate_cmd_d && low_side_fault_enable)
            ls_armed <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!por_n || !ls_armed || !(gm_s2 && dm_s2))
            ls_cnt <= '0;
        else if (ls_cnt != ls_limit)
            ls_cnt <= ls_cnt + 1'b1;
    end

    // fault latch, cleared on next turn-on
    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            ls_fault <= 1'b0;
        else if (ls_armed && gm_s2 && dm_s2 && ls_cnt == ls_limit)
            ls_fault <= 1'b1;
        else if (gate_cmd && !gate_cmd_d)
            ls_fault <= 1'b0;
    end

    // gate off at once, FETs off on timeout
    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            gate_drive <= 1'b0;
        else
            gate_drive <= gate_cmd && !ls_fault && !sw_timeout
                && !(ls_armed && gm_s2 && dm_s2 && ls_cnt == ls_limit);
    end

    // ----------------------------------------
    // Oscillator watchdog
    // ----------------------------------------
    logic [SAMPLE_W-1:0] ref_ticks;
    logic [OSC_W-1:0]    osc_cnt;
    logic                ref_rise;

    assign ref_rise = ref_s2 && !ref_d;

    // count main clocks per reference window
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !oscillator_watchdog_enable)
        begin
            ref_ticks <= '0;
            osc_cnt   <= '0;
        end
        else if (ref_rise && ref_ticks == SAMPLE_W'(OSC_WIN_TICKS - 1))
        begin
            ref_ticks <= '0;
            osc_cnt   <= '0;
        end
        else
        begin
            if (ref_rise)
                ref_ticks <= ref_ticks + 1'b1;
            if (osc_cnt != '1)
                osc_cnt <= osc_cnt + 1'b1;
        end
    end

    // low, high, nominal band, fixed thresholds, disable
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !oscillator_watchdog_enable)
            osc_fail <= 1'b0;
        else if (ref_rise && ref_ticks == SAMPLE_W'(OSC_WIN_TICKS - 1))
            osc_fail <= (osc_cnt < OSC_W'(OSC_MIN_CNT)) || (osc_cnt > OSC_W'(OSC_MAX_CNT));
        else if (osc_cnt > OSC_W'(OSC_MAX_CNT))
            osc_fail <= 1'b1;
    end

    assign digital_reset = !por_n;

    // ----------------------------------------
    // Software watchdog
    // ----------------------------------------
    logic [SW_WD_W-1:0] sw_cnt;

    // cleared by power-on and serial reset, kept on timeout
    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            software_watchdog_enable <= 1'b0;
        else if (serial_core_reset || software_watchdog_enable_clr)
            software_watchdog_enable <= 1'b0;
        else if (software_watchdog_enable_set)
            software_watchdog_enable <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!por_n || !software_watchdog_enable || (svc_s2 != svc_d) || sw_timeout)
            sw_cnt <= '0;
        else
            sw_cnt <= sw_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            sw_timeout <= 1'b0;
        else
            sw_timeout <= software_watchdog_enable && (svc_s2 == svc_d)
                && sw_cnt == SW_WD_W'(SW_WD_CYC - 1);
    end

    assign drive_off = sw_timeout;

    // ----------------------------------------
    // Trim check and RAM self test
    // ----------------------------------------
    dds_bist_type       bist_state;
    logic [BIST_W-1:0]  bist_cnt;
    logic               trim_fail;
    logic               trim_done;
    logic               bist_fail;

    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
        begin
            trim_done <= 1'b0;
            trim_fail <= 1'b0;
        end
        else if (!trim_done)
        begin
            trim_done <= 1'b1;
            trim_fail <= !trim_valid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
        begin
            bist_state <= DDS_BIST_IDLE;
            bist_cnt   <= '0;
            bist_fail  <= 1'b0;
        end
        else
        begin
            unique case (bist_state)
                DDS_BIST_IDLE:
                    bist_state <= DDS_BIST_RUN;
                DDS_BIST_RUN:
                begin
                    if (!bist_pass)
                        bist_fail <= 1'b1;
                    if (bist_cnt == BIST_W'(BIST_CYC - 1))
                        bist_state <= DDS_BIST_END;
                    else
                        bist_cnt <= bist_cnt + 1'b1;
                end
                DDS_BIST_END:
                    bist_state <= DDS_BIST_END;
            endcase
        end
    end

    assign bist_run = (bist_state == DDS_BIST_RUN);
    assign ram_self_test_done = (bist_state == DDS_BIST_END);

    // ----------------------------------------
    // Status registers and core reset
    // ----------------------------------------
    // flags, done and failure
    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
        begin
            first_status_register  <= 8'h00;
            second_status_register <= 8'h00;
        end
        else
        begin
            first_status_register                   <= 8'h00;
            first_status_register[MON_COUNT-1:0]    <= mon_fault;
            first_status_register[ST1_TRIM_FAIL]    <= trim_fail;
            first_status_register[ST1_BIST_DONE]    <= ram_self_test_done;
            first_status_register[ST1_BIST_FAIL]    <= ram_self_test_done && bist_fail;
            second_status_register                  <= 8'h00;
            second_status_register[ST2_LS_FAULT]    <= ls_fault;
        end
    end

    // hold while violation, timeout reset, until trim checked
    always_ff @(posedge clk_sys)
    begin
        if (!por_n)
            core_reset <= 1'b1;
        else
            core_reset <= (|mon_fault) || sw_timeout || serial_core_reset || !trim_done;
    end

endmodule // dds_supervisor

// ### dv/dds_supervisor_checker.sv
/* Port-level assertions for the diagnostics supervisor.
   Bound to the top module; one clk_sys domain with synchronous rst_n. */
module dds_supervisor_checker
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [3:0] monitor_raw,
    input wire logic       gate_cmd,
    input wire logic       gate_monitor,
    input wire logic       drain_monitor,
    input wire logic       low_side_fault_time_select,
    input wire logic       oscillator_watchdog_enable,
    input wire logic       gate_drive,
    input wire logic       core_reset,
    input wire logic       digital_reset,
    input wire logic       software_watchdog_enable,
    input wire logic [7:0] first_status_register,
    input wire logic [7:0] second_status_register
);
    import dds_pkg::*;

    // ----------
    // Run counters
    // ----------
    logic [15:0] ov_run;
    logic [15:0] uv_run;
    logic [15:0] ls_run;

    always_ff @(posedge clk_sys)
    begin
        ov_run <= monitor_raw[0] ? ov_run + {15'h0000, ~&ov_run} : 16'h0000;
        uv_run <= monitor_raw[1] ? uv_run + {15'h0000, ~&uv_run} : 16'h0000;
        ls_run <= (gate_monitor && drain_monitor) ? ls_run + {15'h0000, ~&ls_run} : 16'h0000;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ----------
    // Assertions
    // ----------
    a_core_held_fault: assert property (
        (first_status_register[3:0] != 4'h0) |-> core_reset)
        else $error("power fault without core reset");
    a_ov_deglitch_time: assert property (
        $rose(first_status_register[ST1_SUPPLY_OV]) |-> ov_run >= 16'(OV_DEGLITCH_CYC))
        else $error("overvoltage flag too early");
    a_uv_deglitch_time: assert property (
        $rose(first_status_register[ST1_REG_UV]) |-> uv_run >= 16'(SLOW_DEGLITCH_CYC))
        else $error("undervoltage flag too early");
    a_flag_clear_fast: assert property (
        $fell(monitor_raw[0]) |-> ##[1:4] !first_status_register[ST1_SUPPLY_OV])
        else $error("overvoltage flag not cleared");
    a_ls_trip_time: assert property (
        $rose(second_status_register[ST2_LS_FAULT]) |->
            ls_run >= (low_side_fault_time_select ? 16'(LS_LONG_CYC) : 16'(LS_SHORT_CYC)))
        else $error("low-side fault too early");
    a_ls_gate_off: assert property (
        $rose(second_status_register[ST2_LS_FAULT]) |-> !gate_drive)
        else $error("gate still on with low-side fault");
    a_ls_clear_cmd: assert property (
        $rose(gate_cmd) && second_status_register[ST2_LS_FAULT]
            |-> ##[1:3] !second_status_register[ST2_LS_FAULT])
        else $error("low-side flag not cleared on command");
    a_osc_off_quiet: assert property (
        !oscillator_watchdog_enable [*4] |-> !digital_reset)
        else $error("core reset while oscillator check off");
    a_osc_reset_clears: assert property (
        digital_reset |=> !software_watchdog_enable && second_status_register == 8'h00)
        else $error("core reset left registers set");

    c_ov_fault: cover property ($rose(first_status_register[ST1_SUPPLY_OV]));
    c_ls_fault: cover property ($rose(second_status_register[ST2_LS_FAULT]));
    c_osc_reset: cover property ($rose(digital_reset));
endmodule // dds_supervisor_checker

bind dds_supervisor dds_supervisor_checker u_chk
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .monitor_raw(monitor_raw),
    .gate_cmd(gate_cmd),
    .gate_monitor(gate_monitor),
    .drain_monitor(drain_monitor),
    .low_side_fault_time_select(low_side_fault_time_select),
    .oscillator_watchdog_enable(oscillator_watchdog_enable),
    .gate_drive(gate_drive),
    .core_reset(core_reset),
    .digital_reset(digital_reset),
    .software_watchdog_enable(software_watchdog_enable),
    .first_status_register(first_status_register),
    .second_status_register(second_status_register)
);

// ### dv/dds_supervisor_bench.sv
/* Self-checking bench for the diagnostics supervisor, one task per scenario.
   Package counts as delivered; long watchdog and self-test periods are
   followed only up to their start. */
module dds_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dds_pkg::*;

`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("Error %0t: got %0h want %0h", $time, (g), (e)); \
        end \
    end

    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       osc_ref_clk = 1'b0;
    logic [3:0] monitor_raw = 4'h0;
    logic       gate_cmd = 1'b0;
    logic       gate_monitor = 1'b0;
    logic       drain_monitor = 1'b0;
    logic       low_side_fault_enable = 1'b0;
    logic       low_side_fault_time_select = 1'b0;
    logic       oscillator_watchdog_enable = 1'b1;
    logic       software_watchdog_enable_set = 1'b0;
    logic       software_watchdog_enable_clr = 1'b0;
    logic       serial_core_reset = 1'b0;
    logic       service_pin = 1'b0;
    logic       trim_valid = 1'b0;
    logic       bist_pass = 1'b1;
    logic       gate_drive;
    logic       drive_off;
    logic       core_reset;
    logic       digital_reset;
    logic       software_watchdog_enable;
    logic [7:0] first_status_register;
    logic [7:0] second_status_register;
    logic       ram_self_test_done;
    logic       bist_run;
    int         error_cnt = 0;
    int         check_count = 0;
    int         ref_half = 1000;

    dds_supervisor uut
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .osc_ref_clk(osc_ref_clk),
        .monitor_raw(monitor_raw),
        .gate_cmd(gate_cmd),
        .gate_monitor(gate_monitor),
        .drain_monitor(drain_monitor),
        .low_side_fault_enable(low_side_fault_enable),
        .low_side_fault_time_select(low_side_fault_time_select),
        .oscillator_watchdog_enable(oscillator_watchdog_enable),
        .software_watchdog_enable_set(software_watchdog_enable_set),
        .software_watchdog_enable_clr(software_watchdog_enable_clr),
        .serial_core_reset(serial_core_reset),
        .service_pin(service_pin),
        .trim_valid(trim_valid),
        .bist_pass(bist_pass),
        .gate_drive(gate_drive),
        .drive_off(drive_off),
        .core_reset(core_reset),
        .digital_reset(digital_reset),
        .software_watchdog_enable(software_watchdog_enable),
        .first_status_register(first_status_register),
        .second_status_register(second_status_register),
        .ram_self_test_done(ram_self_test_done),
        .bist_run(bist_run)
    );

    // ----------
    // Clocks and helpers
    // ----------
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        forever #(ref_half) osc_ref_clk = ~osc_ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wait_dr(input logic lvl, input int lim);
        for (int i = 0; i < lim && digital_reset !== lvl; i++)
            cyc(1);
    endtask

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        cyc(16);
        `CHK(core_reset, 1'b1)
        `CHK(software_watchdog_enable, 1'b0)
        rst_n = 1'b1;
        cyc(4);
        `CHK(core_reset, 1'b0)
        `CHK(first_status_register[ST1_TRIM_FAIL], 1'b1)
        `CHK(bist_run, 1'b1)
        `CHK(ram_self_test_done, 1'b0)
    endtask

    task automatic t_monitor();
        monitor_raw[0] = 1'b1;
        cyc(OV_DEGLITCH_CYC - 20);
        monitor_raw[0] = 1'b0;
        cyc(5);
        `CHK(first_status_register[ST1_SUPPLY_OV], 1'b0)
        monitor_raw[0] = 1'b1;
        cyc(OV_DEGLITCH_CYC + 8);
        `CHK(first_status_register[ST1_SUPPLY_OV], 1'b1)
        `CHK(core_reset, 1'b1)
        monitor_raw[0] = 1'b0;
        cyc(6);
        `CHK(first_status_register[ST1_SUPPLY_OV], 1'b0)
        `CHK(core_reset, 1'b0)
        monitor_raw[3:1] = 3'h7;
        cyc(SLOW_DEGLITCH_CYC - 10);
        `CHK(first_status_register[ST1_BIAS_OC:ST1_REG_UV], 3'h0)
        cyc(18);
        `CHK(first_status_register[ST1_BIAS_OC:ST1_REG_UV], 3'h7)
        monitor_raw[3:1] = 3'h0;
        cyc(6);
        `CHK(first_status_register[ST1_BIAS_OC:ST1_REG_UV], 3'h0)
    endtask

    task automatic t_ls();
        int lim;
        gate_cmd = 1'b1;
        gate_monitor = 1'b1;
        drain_monitor = 1'b1;
        cyc(80);
        `CHK(gate_drive, 1'b1)
        `CHK(second_status_register[ST2_LS_FAULT], 1'b0)
        low_side_fault_enable = 1'b1;
        for (int sel = 0; sel < 2; sel++)
        begin
            lim = (sel == 1) ? LS_LONG_CYC : LS_SHORT_CYC;
            low_side_fault_time_select = sel[0];
            gate_cmd = 1'b0;
            gate_monitor = 1'b0;
            drain_monitor = 1'b0;
            cyc(3);
            gate_cmd = 1'b1;
            gate_monitor = 1'b1;
            drain_monitor = 1'b1;
            cyc(lim - 8);
            `CHK(gate_drive, 1'b1)
            cyc(20);
            `CHK(gate_drive, 1'b0)
            `CHK(second_status_register[ST2_LS_FAULT], 1'b1)
            gate_cmd = 1'b0;
            gate_monitor = 1'b0;
            drain_monitor = 1'b0;
            cyc(3);
            gate_cmd = 1'b1;
            cyc(4);
            `CHK(second_status_register[ST2_LS_FAULT], 1'b0)
            `CHK(gate_drive, 1'b1)
        end
        gate_cmd = 1'b0;
        cyc(2);
    endtask

    task automatic t_sw();
        software_watchdog_enable_set = 1'b1;
        cyc(1);
        software_watchdog_enable_set = 1'b0;
        cyc(2);
        `CHK(software_watchdog_enable, 1'b1)
        repeat (4)
        begin
            service_pin = ~service_pin;
            cyc(50);
        end
        `CHK(core_reset, 1'b0)
        `CHK(drive_off, 1'b0)
        serial_core_reset = 1'b1;
        cyc(3);
        `CHK(core_reset, 1'b1)
        `CHK(software_watchdog_enable, 1'b0)
        `CHK(first_status_register[ST1_TRIM_FAIL], 1'b1)
        serial_core_reset = 1'b0;
        cyc(3);
        `CHK(core_reset, 1'b0)
        software_watchdog_enable_set = 1'b1;
        software_watchdog_enable_clr = 1'b1;
        cyc(1);
        software_watchdog_enable_set = 1'b0;
        software_watchdog_enable_clr = 1'b0;
        cyc(2);
        `CHK(software_watchdog_enable, 1'b0)
    endtask

    task automatic t_osc();
        bit seen;
        seen = 1'b0;
        software_watchdog_enable_set = 1'b1;
        cyc(1);
        software_watchdog_enable_set = 1'b0;
        repeat (2000)
        begin
            cyc(1);
            if (digital_reset !== 1'b0)
                seen = 1'b1;
        end
        `CHK(seen, 1'b0)
        ref_half = 100;
        wait_dr(1'b1, 3000);
        `CHK(digital_reset, 1'b1)
        cyc(1);
        `CHK(software_watchdog_enable, 1'b0)
        trim_valid = 1'b1;
        ref_half = 1000;
        wait_dr(1'b0, 4000);
        `CHK(digital_reset, 1'b0)
        cyc(4);
        `CHK(first_status_register[ST1_TRIM_FAIL], 1'b0)
        ref_half = 10000;
        wait_dr(1'b1, 20000);
        `CHK(digital_reset, 1'b1)
        oscillator_watchdog_enable = 1'b0;
        ref_half = 1000;
        cyc(4);
        `CHK(digital_reset, 1'b0)
    endtask

    // ----------
    // Main sequence and watchdog
    // ----------
    initial
    begin
        t_reset();
        t_monitor();
        t_ls();
        t_sw();
        t_osc();
        summarize();
    end

    initial
    begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end
endmodule // dds_supervisor_bench
